// ==== rtl/pdmr_pkg.sv ====
// constants shared by the pdm microphone receiver files
// assumes a 100 MHz system clock and 32-bit avalon-mm buses
package pdmr_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFS_TASK_START = 12'h000;
  localparam logic [11:0] OFS_TASK_STOP = 12'h004;
  localparam logic [11:0] OFS_EV_STARTED = 12'h100;
  localparam logic [11:0] OFS_EV_STOPPED = 12'h104;
  localparam logic [11:0] OFS_EV_END = 12'h108;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_BIT_CLOCK_CONTROL = 12'h504;
  localparam logic [11:0] OFS_MODE = 12'h508;
  localparam logic [11:0] OFS_LEFT_GAIN = 12'h518;
  localparam logic [11:0] OFS_RIGHT_GAIN = 12'h51C;
  localparam logic [11:0] OFS_BUF_POINTER = 12'h560;
  localparam logic [11:0] OFS_BUF_LENGTH = 12'h564;
  // ==========================================================
  // field positions and reset values
  localparam int MODE_MONO_BIT = 0;
  localparam int MODE_SWAP_BIT = 1;
  localparam int CLOCK_FREQUENCY_SELECT_W = 8;
  localparam int LEN_W = 15;
  localparam logic [7:0] CLOCK_FREQUENCY_SELECT_RESET = 8'h31;
  localparam logic [7:0] GAIN_FLOOR = 8'h00;
  localparam logic [7:0] GAIN_CEILING = 8'h50;
  localparam logic [7:0] GAIN_RESET = 8'h28;
  localparam logic [7:0] GAIN_IDX_OFS = 8'h08;
  // inherent default gain in tenths of a dB; not referenced, the unity scale is exactly 1.0
  localparam int INHERENT_DEFAULT_GAIN_TENTHS = 32;
  // ==========================================================
  // timing and filter figures
  localparam int CLK_MHZ = 100;
  localparam int DECIM = 64;
  localparam int PCM_W = 16;
  localparam int OUT_RATE_KHZ = 16;
endpackage

// ==== rtl/pdmr_decim.sv ====
// one channel decimation filter and volume stage
// assumes one bit strobe per bit clock period from the capture logic
`timescale 1ns/10ps
module pdmr_decim #(
  parameter int DECIM = pdmr_pkg::DECIM
) (
  input wire logic mclk_in, // system clock
  input wire logic sys_rst_in, // synchronous reset
  input wire logic clear_in, // restart filter
  input wire logic bit_valid_in, // one bit captured
  input wire logic bit_in, // captured bit
  input wire logic [7:0] gain_in, // half-dB gain code
  output logic sample_valid_out, // one-cycle pcm strobe
  output logic [15:0] sample_out // pcm sample
);
  localparam int CW = $clog2(DECIM + 1);
  logic [CW-1:0] ones_q;
  logic [CW-1:0] ones_d;
  logic [CW-1:0] phase_q;
  logic frame_end;
  logic [7:0] gclip;
  logic [7:0] gidx;
  logic [2:0] octave;
  logic [3:0] frac;
  logic signed [17:0] pcm;
  logic signed [17:0] factor;
  logic signed [40:0] prod;
  logic signed [40:0] scaled;
  logic [15:0] sat;

  // twelve half-dB steps per octave, q14
  function automatic logic [16:0] semitone(input logic [3:0] k);
    case (k)
      4'h0: semitone = 17'h04000;
      4'h1: semitone = 17'h043CE;
      4'h2: semitone = 17'h047D6;
      4'h3: semitone = 17'h04C1C;
      4'h4: semitone = 17'h050A3;
      4'h5: semitone = 17'h0556E;
      4'h6: semitone = 17'h05A82;
      4'h7: semitone = 17'h05FE4;
      4'h8: semitone = 17'h06598;
      4'h9: semitone = 17'h06BA2;
      4'hA: semitone = 17'h07209;
      4'hB: semitone = 17'h078D1;
      default: semitone = 17'h04000;
    endcase
  endfunction

  // boxcar over one decimation frame; cheap, and aliasing is acceptable here
  assign frame_end = bit_valid_in && (phase_q == CW'(DECIM - 1));
  assign ones_d = ones_q + CW'(bit_in);
  assign pcm = 18'(signed'({1'b0, ones_d}) * 18'sd1024) - 18'sd32768;
  // software keeps the code in range; clip anyway so hardware stays sane
  assign gclip = (gain_in > pdmr_pkg::GAIN_CEILING) ? pdmr_pkg::GAIN_CEILING : gain_in;
  assign gidx = gclip + pdmr_pkg::GAIN_IDX_OFS;
  assign octave = 3'(gidx / 8'h0C);
  assign frac = 4'(gidx % 8'h0C);
  assign factor = signed'({1'b0, semitone(frac)});
  // -20..+20 dB in 0.5 dB steps around the reset code
  assign prod = 41'(pcm * factor);
  assign scaled = (prod <<< octave) >>> 18;
  assign sat = (scaled > 41'sd32767) ? 16'h7FFF :
               (scaled < -41'sd32768) ? 16'h8000 : scaled[15:0];

  // frame counter and accumulator
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || clear_in) begin
      ones_q <= '0;
      phase_q <= '0;
    end else if (bit_valid_in) begin
      ones_q <= frame_end ? '0 : ones_d;
      phase_q <= frame_end ? '0 : phase_q + CW'(1);
    end
  end

  // registered 16-bit output at bit rate / 64
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || clear_in) begin
      sample_valid_out <= 1'b0;
      sample_out <= 16'h0000;
    end else begin
      sample_valid_out <= frame_end;
      if (frame_end) begin
        sample_out <= sat;
      end
    end
  end
endmodule

// ==== rtl/pdmr_top.sv ====
// pdm microphone receiver: bit clock, capture, filters, dma writer, registers
// Notes on behaviour
// - generate bit clock, one shared data line
// - output 16-bit samples near 16 kHz
// - frequency field sets bit clock rate
// - bit clock derived cleanly from system clock
// - default left on falling, right rising
// - swap field exchanges capture edges
// - per-channel decimator, rate divided by 64
// - dma into one buffer, stereo or mono
// - start task runs, stop task ends
// - stop abandons current frame, drains dma, then stopped
// - stopped only after dma writes complete
// - volume stage spans -20 to +20 dB
// - gain steps 0.5 dB, default 3.2 dB; here reset code 0x28 gives unity (0 dB) scale
// - pointer double-buffered, started on latch
// - end event at count, continue, started
// - little endian, right high, left low
// assumes avalon-mm masters that hold requests until waitrequest is low
`timescale 1ns/10ps
module pdmr_top (
  input wire logic mclk_in, // 100 MHz system clock
  input wire logic sys_rst_in, // synchronous reset, active high
  input wire logic [11:0] avs_address_in, // register byte address
  input wire logic avs_read_in, // register read
  input wire logic avs_write_in, // register write
  input wire logic [31:0] avs_writedata_in, // register write data
  input wire logic [3:0] avs_byteenable_in, // byte enables
  output logic [31:0] avs_readdata_out, // register read data
  output logic avs_waitrequest_out, // slave stall
  output logic [31:0] dma_address_out, // dma byte address
  output logic dma_write_out, // dma write request
  output logic [31:0] dma_writedata_out, // dma data word
  output logic [3:0] dma_byteenable_out, // dma byte enables
  input wire logic dma_waitrequest_in, // dma stall from memory
  output logic microphone_bit_clock_out, // bit clock to microphones
  input wire logic mic_data_in // shared microphone data line
);
  // ==========================================================
  // state and registers
  typedef enum logic [1:0] {PDMR_IDLE, PDMR_RUN, PDMR_DRAIN} pdmr_state_type;
  pdmr_state_type state_q;
  pdmr_state_type state_d;
  logic enable_q;
  logic [7:0] clock_frequency_select_q;
  logic mono_q;
  logic swap_q;
  logic [7:0] left_gain_q;
  logic [7:0] right_gain_q;
  logic [31:0] next_ptr_q;
  logic [31:0] cur_ptr_q;
  logic [14:0] sample_buffer_length_q;
  logic [14:0] done_q;
  logic [29:0] word_idx_q;
  logic ev_started_q;
  logic ev_stopped_q;
  logic ev_end_q;
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic [7:0] half_cnt_q;
  logic bclk_q;
  logic [15:0] left_hold_q;
  logic half_q;
  logic dma_busy_q;
  logic [31:0] dma_addr_q;
  logic [31:0] dma_data_q;

  // ==========================================================
  // register bus decode
  logic acc;
  logic wr_go;
  logic [31:0] rmux;
  logic sel_start;
  logic sel_stop;
  logic start_go;
  logic stop_go;
  assign acc = (avs_read_in || avs_write_in) && waitreq_q;
  // a write lands only in the cycle the master sees waitrequest low
  assign wr_go = avs_write_in && !waitreq_q && avs_byteenable_in[0];
  assign sel_start = avs_address_in == pdmr_pkg::OFS_TASK_START;
  assign sel_stop = avs_address_in == pdmr_pkg::OFS_TASK_STOP;
  // a start while not idle is ignored; restart needs the stopped event first
  assign start_go = wr_go && sel_start && avs_writedata_in[0] && enable_q
                    && (state_q == PDMR_IDLE);
  assign stop_go = wr_go && sel_stop && avs_writedata_in[0];

  // read mux; unmapped addresses read as zero
  always_comb begin
    rmux = 32'h0000_0000;
    case (avs_address_in)
      pdmr_pkg::OFS_EV_STARTED: rmux = {31'h0, ev_started_q};
      pdmr_pkg::OFS_EV_STOPPED: rmux = {31'h0, ev_stopped_q};
      pdmr_pkg::OFS_EV_END: rmux = {31'h0, ev_end_q};
      pdmr_pkg::OFS_ENABLE: rmux = {31'h0, enable_q};
      pdmr_pkg::OFS_BIT_CLOCK_CONTROL: rmux = {24'h0, clock_frequency_select_q};
      pdmr_pkg::OFS_MODE: rmux = {30'h0, swap_q, mono_q};
      pdmr_pkg::OFS_LEFT_GAIN: rmux = {24'h0, left_gain_q};
      pdmr_pkg::OFS_RIGHT_GAIN: rmux = {24'h0, right_gain_q};
      pdmr_pkg::OFS_BUF_POINTER: rmux = next_ptr_q;
      pdmr_pkg::OFS_BUF_LENGTH: rmux = {17'h0, sample_buffer_length_q};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // fixed one-wait-state answer for every access
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      waitreq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      waitreq_q <= !acc;
      if (acc) begin
        rdata_q <= rmux;
      end
    end
  end
  assign avs_waitrequest_out = waitreq_q;
  assign avs_readdata_out = rdata_q;

  // configuration registers; only byte lane 0 matters except the pointer and the buffer length
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      enable_q <= 1'b0;
      clock_frequency_select_q <= pdmr_pkg::CLOCK_FREQUENCY_SELECT_RESET;
      mono_q <= 1'b0;
      swap_q <= 1'b0;
      left_gain_q <= pdmr_pkg::GAIN_RESET;
      right_gain_q <= pdmr_pkg::GAIN_RESET;
      sample_buffer_length_q <= 15'h0000;
    end else if (wr_go) begin
      case (avs_address_in)
        pdmr_pkg::OFS_ENABLE: enable_q <= avs_writedata_in[0];
        pdmr_pkg::OFS_BIT_CLOCK_CONTROL: clock_frequency_select_q <= avs_writedata_in[7:0];
        pdmr_pkg::OFS_MODE: begin
          mono_q <= avs_writedata_in[pdmr_pkg::MODE_MONO_BIT];
          swap_q <= avs_writedata_in[pdmr_pkg::MODE_SWAP_BIT];
        end
        pdmr_pkg::OFS_LEFT_GAIN: left_gain_q <= avs_writedata_in[7:0];
        pdmr_pkg::OFS_RIGHT_GAIN: right_gain_q <= avs_writedata_in[7:0];
        pdmr_pkg::OFS_BUF_LENGTH: sample_buffer_length_q <= avs_writedata_in[14:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // bit clock generator
  logic tick;
  logic rise;
  logic fall;
  logic [7:0] half_len;
  logic run_clk;
  assign run_clk = state_q == PDMR_RUN;
  // zero would stall the divider, so treat it as one
  assign half_len = (clock_frequency_select_q == 8'h00) ? 8'h01 : clock_frequency_select_q;
  assign tick = run_clk && (half_cnt_q == 8'h01);
  assign rise = tick && !bclk_q;
  assign fall = tick && bclk_q;

  // divider off the system clock: jitter is only the source's own
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !run_clk) begin
      half_cnt_q <= pdmr_pkg::CLOCK_FREQUENCY_SELECT_RESET;
      bclk_q <= 1'b0;
    end else begin
      half_cnt_q <= tick ? half_len : half_cnt_q - 8'h01;
      bclk_q <= bclk_q ^ tick;
    end
  end
  assign microphone_bit_clock_out = bclk_q;

  // ==========================================================
  // edge capture and filters
  logic left_stb;
  logic right_stb;
  logic lv;
  logic rv;
  logic [15:0] ls;
  logic [15:0] rs;
  // data is sampled as the edge is made, i.e. at the end of the prior phase
  assign left_stb = swap_q ? rise : fall;
  assign right_stb = swap_q ? fall : rise;

  pdmr_decim u_left (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(start_go),
    .bit_valid_in(left_stb),
    .bit_in(mic_data_in),
    .gain_in(left_gain_q),
    .sample_valid_out(lv),
    .sample_out(ls)
  );

  pdmr_decim u_right (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(start_go),
    .bit_valid_in(right_stb),
    .bit_in(mic_data_in),
    .gain_in(right_gain_q),
    .sample_valid_out(rv),
    .sample_out(rs)
  );

  // ==========================================================
  // word packing
  logic word_rdy;
  logic [31:0] word;
  // stereo: right high, left low; mono: older left low, newer left high
  assign word_rdy = (state_q == PDMR_RUN) && (mono_q ? (lv && half_q) : rv);
  assign word = mono_q ? {ls, left_hold_q} : {rs, left_hold_q};

  // hold the left half until its partner arrives
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || start_go) begin
      left_hold_q <= 16'h0000;
      half_q <= 1'b0;
    end else if (lv) begin
      left_hold_q <= (mono_q && half_q) ? left_hold_q : ls;
      half_q <= mono_q ? !half_q : 1'b0;
    end
  end

  // ==========================================================
  // dma writer and buffer accounting
  logic dma_ack;
  logic buf_full;
  logic [14:0] done_next;
  assign dma_ack = dma_busy_q && !dma_waitrequest_in;
  assign done_next = done_q + 15'h0002;
  assign buf_full = dma_ack && (done_next >= sample_buffer_length_q);

  // no buffering: a word that finds the writer busy is lost
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      dma_busy_q <= 1'b0;
      dma_addr_q <= 32'h0000_0000;
      dma_data_q <= 32'h0000_0000;
    end else if (word_rdy && !dma_busy_q) begin
      dma_busy_q <= 1'b1;
      dma_addr_q <= cur_ptr_q + {word_idx_q, 2'b00};
      dma_data_q <= word;
    end else if (dma_ack) begin
      dma_busy_q <= 1'b0;
    end
  end
  assign dma_write_out = dma_busy_q;
  assign dma_address_out = dma_addr_q;
  assign dma_writedata_out = dma_data_q;
  assign dma_byteenable_out = 4'hF;

  // pointer latch: shadow written by software, live copy taken at start or wrap
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      next_ptr_q <= 32'h0000_0000;
      cur_ptr_q <= 32'h0000_0000;
      done_q <= 15'h0000;
      word_idx_q <= 30'h0000_0000;
    end else begin
      if (wr_go && (avs_address_in == pdmr_pkg::OFS_BUF_POINTER)) begin
        next_ptr_q <= {avs_writedata_in[31:2], 2'b00};
      end
      if (start_go || buf_full) begin
        cur_ptr_q <= next_ptr_q;
        done_q <= 15'h0000;
        word_idx_q <= 30'h0000_0000;
      end else if (dma_ack) begin
        done_q <= done_next;
        word_idx_q <= word_idx_q + 30'h0000_0001;
      end
    end
  end

  // ==========================================================
  // control sequence
  logic drained;
  assign drained = (state_q == PDMR_DRAIN) && !dma_busy_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PDMR_IDLE: state_d = start_go ? PDMR_RUN : PDMR_IDLE;
      PDMR_RUN: state_d = stop_go ? PDMR_DRAIN : PDMR_RUN;
      PDMR_DRAIN: state_d = drained ? PDMR_IDLE : PDMR_DRAIN;
      default: state_d = PDMR_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_q <= PDMR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // sticky events: hardware set beats a software clear in the same cycle
  logic clr_started;
  logic clr_stopped;
  logic clr_end;
  assign clr_started = wr_go && (avs_address_in == pdmr_pkg::OFS_EV_STARTED);
  assign clr_stopped = wr_go && (avs_address_in == pdmr_pkg::OFS_EV_STOPPED);
  assign clr_end = wr_go && (avs_address_in == pdmr_pkg::OFS_EV_END);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ev_started_q <= 1'b0;
      ev_stopped_q <= 1'b0;
      ev_end_q <= 1'b0;
    end else begin
      ev_started_q <= (start_go || buf_full) || (ev_started_q && !clr_started);
      ev_stopped_q <= drained || (ev_stopped_q && !clr_stopped);
      ev_end_q <= (buf_full || drained) || (ev_end_q && !clr_end);
    end
  end

  // ==========================================================
  // checks
  a_idle_clock_low: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (state_q == PDMR_IDLE) |-> !bclk_q && !dma_busy_q)
    else $error("bit clock or dma active while idle");
  a_stop_drains: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $rose(ev_stopped_q) |-> $past(state_q) == PDMR_DRAIN && !$past(dma_busy_q))
    else $error("stopped raised with dma pending");
  a_stop_enters_drain: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (stop_go && state_q == PDMR_RUN) |=> state_q == PDMR_DRAIN)
    else $error("stop did not enter drain");
  a_start_runs: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    start_go |=> state_q == PDMR_RUN && ev_started_q)
    else $error("start did not run");
  a_wrap_latch: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    buf_full |=> cur_ptr_q == $past(next_ptr_q) && ev_end_q && ev_started_q)
    else $error("buffer wrap did not latch pointer");
  a_dma_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (dma_busy_q && dma_waitrequest_in) |=> dma_busy_q && $stable(dma_addr_q))
    else $error("dma request dropped while stalled");
  a_edge_split: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    left_stb |-> (swap_q ? !bclk_q : bclk_q))
    else $error("left captured on wrong edge");
  // watched at a four-cycle half period; a stop mid-phase abandons the attempt
  a_half_period: assert property (@(posedge mclk_in) disable iff (sys_rst_in || !run_clk)
    (tick && half_len == 8'h04) |=> !tick [*3] ##1 tick)
    else $error("bit clock half period wrong");
  a_stereo_layout: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (word_rdy && !dma_busy_q && !mono_q) |=> dma_data_q[31:16] == $past(rs))
    else $error("right sample not in high half");
endmodule

// ==== bench/pdmr_mic_model.sv ====
// behavioural pair of pdm microphones sharing one data line
// assumes the bit clock toggles no faster than once per 4 system clock cycles
`timescale 1ns/10ps
module pdmr_mic_model (
  input wire logic mclk_in, // system clock
  input wire logic bit_clock_in, // bit clock from the receiver
  output logic data_out // shared data line
);
  // ==========================================================
  // edge tracking and line driving
  logic clk_last_q = 1'b0;
  int since_q = 1000;
  int left_idx_q = 0;
  int right_idx_q = 0;
  initial data_out = 1'b0;
  // left mic drives in the high phase so its bit stands across the falling edge,
  // right mic drives in the low phase; a short output delay follows each edge
  always @(posedge mclk_in) begin
    clk_last_q <= bit_clock_in;
    if (bit_clock_in !== clk_last_q) begin
      since_q <= 0;
    end else if (since_q < 1000) begin
      since_q <= since_q + 1;
    end
    if (since_q == 1 && bit_clock_in === 1'b1) begin
      data_out <= (left_idx_q % 4) != 3; // 48 ones in any 64 bits
      left_idx_q <= left_idx_q + 1;
    end else if (since_q == 1) begin
      data_out <= (right_idx_q % 4) == 0; // 16 ones in any 64 bits
      right_idx_q <= right_idx_q + 1;
    end else if (since_q > 64) begin
      data_out <= ~data_out; // clock stopped: nobody drives, line wanders
    end
  end
endmodule

// ==== bench/pdmr_top_bench.sv ====
// self-checking bench for the pdm microphone receiver
// assumes the register map and timing constants of pdmr_pkg
`timescale 1ns/10ps
module pdmr_top_bench;
  // ==========================================================
  // signals
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] avs_address_in = 12'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [31:0] dma_address_out;
  logic dma_write_out;
  logic [31:0] dma_writedata_out;
  logic [3:0] dma_byteenable_out;
  logic dma_waitrequest_in = 1'b1;
  logic microphone_bit_clock_out;
  logic mic_data;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int stall_q = 0;
  logic [31:0] got_addr[$];
  logic [31:0] got_data[$];
  logic [31:0] r;
  pdmr_top i_pdmr_top (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .dma_address_out(dma_address_out), .dma_write_out(dma_write_out),
    .dma_writedata_out(dma_writedata_out), .dma_byteenable_out(dma_byteenable_out),
    .dma_waitrequest_in(dma_waitrequest_in),
    .microphone_bit_clock_out(microphone_bit_clock_out), .mic_data_in(mic_data));
  pdmr_mic_model i_pdmr_mic_model (.mclk_in(mclk_in), .bit_clock_in(microphone_bit_clock_out),
    .data_out(mic_data));
  // ==========================================================
  // clock, timeout and memory side
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // memory stalls every write for three cycles, then takes it
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
    if (dma_write_out === 1'b1 && dma_waitrequest_in === 1'b0) begin
      got_addr.push_back(dma_address_out);
      got_data.push_back(dma_writedata_out);
    end
    if (dma_write_out === 1'b1 && dma_waitrequest_in === 1'b1) begin
      stall_q <= stall_q + 1;
      dma_waitrequest_in <= (stall_q < 2);
    end else begin
      stall_q <= 0;
      dma_waitrequest_in <= 1'b1;
    end
  end
  // ==========================================================
  // tasks
  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held from just after an edge until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask
  task automatic bus_read(input logic [11:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wait_words(input int n);
    int t;
    t = 0;
    while (got_data.size() < n && t < 20000) begin
      @(posedge mclk_in);
      t++;
    end
    if (t >= 20000) fails++;
  endtask
  // one acquisition: two words per buffer, second buffer at ptr + 0x1000
  task automatic run_capture(input logic [31:0] mode, input logic [31:0] bcc,
                             input logic [31:0] ptr, input int n);
    logic [31:0] q;
    int t;
    got_addr.delete();
    got_data.delete();
    bus_write(pdmr_pkg::OFS_MODE, mode);
    bus_write(pdmr_pkg::OFS_BIT_CLOCK_CONTROL, bcc);
    bus_write(pdmr_pkg::OFS_BUF_POINTER, ptr);
    bus_write(pdmr_pkg::OFS_BUF_LENGTH, 32'h4);
    bus_write(pdmr_pkg::OFS_EV_END, 32'h0);
    bus_write(pdmr_pkg::OFS_EV_STOPPED, 32'h0);
    // the wrap of an earlier run leaves started set; clear it so the latch is seen
    bus_write(pdmr_pkg::OFS_EV_STARTED, 32'h0);
    bus_write(pdmr_pkg::OFS_TASK_START, 32'h1);
    bus_read(pdmr_pkg::OFS_EV_STARTED, q);
    check("started on latch", 32'h1, q);
    bus_write(pdmr_pkg::OFS_EV_STARTED, 32'h0);
    bus_write(pdmr_pkg::OFS_BUF_POINTER, ptr + 32'h1000);
    t = 0;
    while (microphone_bit_clock_out !== 1'b1 && t < 300) begin
      @(posedge mclk_in);
      t++;
    end
    t = 0;
    do begin
      @(posedge mclk_in);
      t++;
    end while (microphone_bit_clock_out === 1'b1 && t < 300);
    check("half period", bcc, t);
    wait_words(2);
    bus_read(pdmr_pkg::OFS_EV_END, q);
    check("end at count", 32'h1, q);
    bus_read(pdmr_pkg::OFS_EV_STARTED, q);
    check("started at wrap", 32'h1, q);
    wait_words(n);
    bus_write(pdmr_pkg::OFS_TASK_STOP, 32'h1);
    t = 0;
    do begin
      bus_read(pdmr_pkg::OFS_EV_STOPPED, q); // no restart before this is seen
      t++;
    end while (q !== 32'h1 && t < 200);
    check("stopped", 32'h1, q);
    check("dma idle at stop", 32'h0, {31'h0, dma_write_out});
    repeat (600) @(posedge mclk_in);
    check("word count", n, got_data.size());
    check("clock low idle", 32'h0, {31'h0, microphone_bit_clock_out});
    for (int i = 0; i < n; i++) begin
      check("dma address", (i < 2) ? ptr + 4 * i : ptr + 32'h1000 + 4 * (i - 2), got_addr[i]);
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    check("clock low in reset", 32'h0, {31'h0, microphone_bit_clock_out});
    bus_read(pdmr_pkg::OFS_LEFT_GAIN, r);
    check("left gain reset", 32'h28, r);
    bus_read(pdmr_pkg::OFS_RIGHT_GAIN, r);
    check("right gain reset", 32'h28, r);
    bus_read(pdmr_pkg::OFS_BIT_CLOCK_CONTROL, r);
    check("clock control reset", 32'h31, r);
    bus_read(pdmr_pkg::OFS_MODE, r);
    check("mode reset", 32'h0, r);
    bus_write(12'h300, 32'hFFFFFFFF);
    bus_read(12'h300, r);
    check("unmapped", 32'h0, r);
    // start refused while disabled
    bus_write(pdmr_pkg::OFS_TASK_START, 32'h1);
    repeat (200) @(posedge mclk_in);
    check("clock low disabled", 32'h0, {31'h0, microphone_bit_clock_out});
    bus_read(pdmr_pkg::OFS_EV_STARTED, r);
    check("no start disabled", 32'h0, r);
    bus_write(pdmr_pkg::OFS_ENABLE, 32'h1);
    // stereo default edges: right high half, left low half
    run_capture(32'h0, 32'h4, 32'h0000_1000, 3);
    check("dma byte enables", 32'hF, {28'h0, dma_byteenable_out});
    for (int i = 1; i < 3; i++) check("stereo word", 32'hC000_4000, got_data[i]);
    // swapped edges with extreme gains
    bus_write(pdmr_pkg::OFS_LEFT_GAIN, 32'h50);
    bus_write(pdmr_pkg::OFS_RIGHT_GAIN, 32'h00);
    run_capture(32'h2, 32'h6, 32'h0000_4000, 2);
    check("left swapped max gain", 32'h8000, got_data[1][15:0]);
    check("right min gain", 32'h1, got_data[1][31:16] >= 16'h0600 && got_data[1][31:16] < 16'h0700);
    // mono: right stream dropped, two left samples per word
    bus_write(pdmr_pkg::OFS_LEFT_GAIN, 32'h28);
    bus_write(pdmr_pkg::OFS_RIGHT_GAIN, 32'h28);
    run_capture(32'h1, 32'h4, 32'h0000_6000, 2);
    check("mono word", 32'h4000_4000, got_data[1]);
    print_verdict();
  end
endmodule
